// >>> logic/ccmsd_top.sv
// Clock mode select, divider and system clock output generator
//
// Behaviour
// - Pattern 101: undivided clock enable, duty-cycle equalizer enabled.
// - Pattern 000: on-chip clock enable every second oscillator cycle.
// - Pattern 001: divider bypassed, equalizer stays disabled.
// - Pattern 010: on-chip clock enable every fourth oscillator cycle.
// - In divide-by-four, system clock output realigns to each reference rising edge within one cycle.
// - Pattern 011: system clock output generator held in known reset.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ccmsd_top
  import ccmsd_pkg::*;
(
  input  wire  logic                         pclk,
  input  wire  logic                         presetn,
  input  wire  ccmsd_pkg::ccmsd_apb_req_type apb_req,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire  logic [2:0]                   clk_mode,
  input  wire  logic                         ref_clock_in,
  output logic                               chip_clk_en,
  output logic                               symmetrator_en,
  output logic                               divider_bypass,
  output logic                               sys_clk_out_true,
  output logic                               sys_clk_out_comp,
  output logic                               mode_invalid
);
  import ccmsd_pkg::*;

  logic [1:0]                     div_cnt;
  logic [HALF_PERIOD_WIDTH-1:0]   sys_cnt;
  logic [HALF_PERIOD_WIDTH-1:0]   half_period;
  logic                           ref_q;
  ccmsd_status_type               status;

  // Mode decode
  wire is_normal = (clk_mode == MODE_NORMAL);
  wire is_div2   = (clk_mode == MODE_DIV2);
  wire is_bypass = (clk_mode == MODE_BYPASS);
  wire is_div4   = (clk_mode == MODE_DIV4);
  wire is_clkrst = (clk_mode == MODE_CLKRST);
  wire is_valid  = is_normal | is_div2 | is_bypass | is_div4 | is_clkrst;

  wire next_chip_clk_en = is_normal | is_bypass
                        | (is_div2 & (div_cnt[0] == DIV2_LAST[0]))
                        | (is_div4 & (div_cnt == DIV4_LAST));
  wire next_symmetrator_en = is_normal;

  // Reference edge realigns the generator in divide-by-four only
  wire ref_rise  = ref_clock_in & ~ref_q;
  wire realign   = is_div4 & ref_rise;
  wire half_last = (sys_cnt >= half_period - 4'h1);
  wire [HALF_PERIOD_WIDTH-1:0] next_sys_cnt =
    (is_clkrst | realign | half_last) ? '0 : sys_cnt + 4'h1;
  // Reset forces low; realign starts a high phase at once
  wire next_sys_out = is_clkrst ? 1'b0
                    : realign ? 1'b1
                    : (half_last ? ~sys_clk_out_true : sys_clk_out_true);

  // Register bus decode
  wire setup    = apb_req.psel & ~apb_req.penable;
  wire access   = apb_req.psel & apb_req.penable & pready;
  wire hit_ctrl = (apb_req.paddr == CTRL_OFFSET);
  wire hit_stat = (apb_req.paddr == STATUS_OFFSET);
  wire unmapped = ~(hit_ctrl | hit_stat);
  wire ctrl_wr  = access & apb_req.pwrite & hit_ctrl;
  // Zero half period would stall the generator, so it clamps to one
  wire [HALF_PERIOD_WIDTH-1:0] next_half_period =
    (apb_req.pwdata[HALF_PERIOD_WIDTH-1:0] == '0) ? 4'h1
    : apb_req.pwdata[HALF_PERIOD_WIDTH-1:0];
  wire [31:0] next_prdata =
    hit_ctrl ? {28'h000_0000, half_period}
    : hit_stat ? {25'h000_0000, status} : 32'h0000_0000;

  assign status = '{mode_invalid:   mode_invalid,
                    gen_reset:      is_clkrst,
                    divider_bypass: divider_bypass,
                    symmetrator_en: symmetrator_en,
                    mode:           clk_mode};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt        <= 2'h0;
      chip_clk_en    <= 1'b0;
      symmetrator_en <= 1'b0;
      divider_bypass <= 1'b0;
      mode_invalid   <= 1'b0;
    end
    else
    begin
      div_cnt        <= div_cnt + 2'h1;
      chip_clk_en    <= next_chip_clk_en;
      symmetrator_en <= next_symmetrator_en;
      divider_bypass <= is_bypass;
      mode_invalid   <= ~is_valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_cnt          <= '0;
      sys_clk_out_true <= 1'b0;
      sys_clk_out_comp <= 1'b1;
      ref_q            <= 1'b0;
    end
    else
    begin
      sys_cnt          <= next_sys_cnt;
      sys_clk_out_true <= next_sys_out;
      sys_clk_out_comp <= ~next_sys_out;
      ref_q            <= ref_clock_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      half_period <= HALF_PERIOD_RESET;
      pready      <= 1'b0;
      prdata      <= 32'h0000_0000;
      pslverr     <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & unmapped;
      if (setup)
      begin
        prdata <= next_prdata;
      end
      if (ctrl_wr)
      begin
        half_period <= next_half_period;
      end
    end
  end

  // Checks
  sequence s_div4_run;
    (clk_mode == MODE_DIV4) [*4] ##1 chip_clk_en;
  endsequence

  sequence s_ref_edge;
    (clk_mode == MODE_DIV4) && ref_clock_in && !ref_q;
  endsequence

  // Three samples keep the past value clear of a reset release
  chk_normal_undivided: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_mode == MODE_NORMAL) [*3] |=> chip_clk_en && $past(chip_clk_en)
      && symmetrator_en && !divider_bypass)
    else $error("normal mode not undivided with equalizer");

  chk_div2_alternate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_mode == MODE_DIV2) [*2] |=> chip_clk_en != $past(chip_clk_en)
      && !symmetrator_en)
    else $error("divide by two enable not alternating");

  chk_bypass_noeq: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_mode == MODE_BYPASS |=> chip_clk_en && divider_bypass
      && !symmetrator_en)
    else $error("bypass mode wrong");

  chk_div4_spacing: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_div4_run |-> !$past(chip_clk_en, 1) && !$past(chip_clk_en, 2)
      && !$past(chip_clk_en, 3))
    else $error("divide by four enable spacing wrong");

  chk_div4_flags: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_mode == MODE_DIV4 |=> !symmetrator_en && !divider_bypass
      && !mode_invalid)
    else $error("divide by four mode flags wrong");

  chk_clkrst_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_mode == MODE_CLKRST |=> !chip_clk_en && !symmetrator_en
      && !divider_bypass)
    else $error("clock reset mode not quiet");

  chk_ref_lock: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ref_edge |=> sys_clk_out_true && !sys_clk_out_comp && sys_cnt == '0)
    else $error("system clock output not locked to reference");

  chk_gen_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_mode == MODE_CLKRST) [*3] |=> !sys_clk_out_true && sys_clk_out_comp
      && $stable(sys_clk_out_true) && sys_cnt == '0)
    else $error("generator not held in reset");

  chk_apb_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_req.psel && !apb_req.penable |=> pready ##1 !pready)
    else $error("bus answer not one cycle after setup");

  chk_unmapped_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_req.psel && !apb_req.penable && apb_req.paddr != CTRL_OFFSET
      && apb_req.paddr != STATUS_OFFSET |=> pslverr && prdata == '0)
    else $error("unmapped access not refused");

  chk_ctrl_clamp: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_wr && apb_req.pwdata[3:0] == 4'h0 |=> half_period == 4'h1)
    else $error("zero half period not clamped");

  chk_invalid_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_mode[2] && (clk_mode[1] || !clk_mode[0]) |=> mode_invalid
      && !chip_clk_en)
    else $error("invalid mode not flagged");
endmodule : ccmsd_top
`default_nettype wire

// >>> logic/ccmsd_pkg.sv
// Package of constants and types for the clock mode select divider
package ccmsd_pkg;
  // Mode select patterns
  localparam logic [2:0] MODE_NORMAL = 3'h5;
  localparam logic [2:0] MODE_DIV2   = 3'h0;
  localparam logic [2:0] MODE_BYPASS = 3'h1;
  localparam logic [2:0] MODE_DIV4   = 3'h2;
  localparam logic [2:0] MODE_CLKRST = 3'h3;
  // Divider terminal counts
  localparam logic [1:0] DIV2_LAST = 2'h1;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  // Control reset value: half period of the system clock output
  localparam logic [3:0] HALF_PERIOD_RESET = 4'h2;
  localparam int         HALF_PERIOD_WIDTH = 4;

  typedef struct packed {
    logic       mode_invalid;
    logic       gen_reset;
    logic       divider_bypass;
    logic       symmetrator_en;
    logic [2:0] mode;
  } ccmsd_status_type;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ccmsd_apb_req_type;
endpackage : ccmsd_pkg

// >>> bench/ccmsd_strap_model.sv
// Board strap and reference source for the clock mode pins
`timescale 1ns/1ps
`default_nettype none
module ccmsd_strap_model
(
  input  wire logic       pclk,
  input  wire logic [2:0] mode_req,
  input  wire logic       ref_req,
  output var  logic [2:0] clk_mode,
  output var  logic       ref_clock_in
);
  // Straps start on the preferred undivided pattern
  initial clk_mode = 3'h5;
  initial ref_clock_in = 1'b0;
  // Pattern only changes when the bench asks; invalid ones are deliberate
  always @(posedge pclk)
  begin
    clk_mode     <= mode_req;
    ref_clock_in <= ref_req;
  end
endmodule : ccmsd_strap_model
`default_nettype wire

// >>> bench/ccmsd_top_tb_top.sv
// Self-checking bench for the clock mode select divider
`timescale 1ns/1ps
`default_nettype none
module ccmsd_top_tb_top;
  import ccmsd_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  ccmsd_apb_req_type apb_req = '0;
  logic [2:0]        mode_req = 3'h5;
  logic              ref_req = 1'b0;
  logic [2:0]        clk_mode;
  logic              ref_clock_in;
  logic [31:0]       prdata;
  logic              pready, pslverr, chip_clk_en, symmetrator_en;
  logic              divider_bypass, sys_clk_out_true, sys_clk_out_comp;
  logic              mode_invalid;
  int                n_errors = 0;
  int                samples_checked = 0;

  always #50 pclk = ~pclk;

  ccmsd_strap_model u_strap (.pclk(pclk), .mode_req(mode_req),
    .ref_req(ref_req), .clk_mode(clk_mode), .ref_clock_in(ref_clock_in));

  ccmsd_top dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_mode(clk_mode), .ref_clock_in(ref_clock_in),
    .chip_clk_en(chip_clk_en), .symmetrator_en(symmetrator_en),
    .divider_bypass(divider_bypass), .sys_clk_out_true(sys_clk_out_true),
    .sys_clk_out_comp(sys_clk_out_comp), .mode_invalid(mode_invalid));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Holds the request until pready is seen high; no wait count assumed
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask : apb

  task automatic t_regs;
    logic [31:0] rd;
    logic        e;
    apb(1'b0, CTRL_OFFSET, '0, rd, e);
    check(rd, 32'h0000_0002);
    apb(1'b1, CTRL_OFFSET, 32'h0000_0000, rd, e);
    apb(1'b0, CTRL_OFFSET, '0, rd, e);
    check(rd, 32'h0000_0001);
    apb(1'b0, STATUS_OFFSET, '0, rd, e);
    check(rd, 32'h0000_000D);
    apb(1'b0, 12'h008, '0, rd, e);
    check({rd[30:0], e}, 32'h0000_0001);
  endtask : t_regs

  task automatic t_modes;
    logic [2:0]  m [6] = '{3'h5, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    int          cnt [6] = '{8, 4, 8, 2, 0, 0};
    // Flags are invalid, equalizer, bypass
    logic [2:0]  fl [6] = '{3'h2, 3'h0, 3'h1, 3'h0, 3'h0, 3'h4};
    logic [31:0] n;
    for (int i = 0; i < 6; i++)
    begin
      mode_req <= m[i];
      repeat (4) @(posedge pclk);
      n = '0;
      repeat (8)
      begin
        @(posedge pclk);
        n = n + chip_clk_en;
      end
      check(n, cnt[i]);
      check({mode_invalid, symmetrator_en, divider_bypass}, fl[i]);
      if (m[i] == MODE_CLKRST)
      begin
        check({sys_clk_out_true, sys_clk_out_comp}, 32'h0000_0001);
      end
    end
  endtask : t_modes

  // Half period of four makes a chance phase match unlikely
  task automatic t_ref;
    logic [31:0] rd;
    logic        e;
    apb(1'b1, CTRL_OFFSET, 32'h0000_0004, rd, e);
    mode_req <= MODE_DIV4;
    repeat (6) @(posedge pclk);
    ref_req <= 1'b1;
    do @(posedge pclk); while (ref_clock_in !== 1'b1);
    repeat (4)
    begin
      @(posedge pclk);
      check({sys_clk_out_true, sys_clk_out_comp}, 32'h0000_0002);
    end
    @(posedge pclk);
    check({sys_clk_out_true, sys_clk_out_comp}, 32'h0000_0001);
    ref_req <= 1'b0;
  endtask : t_ref

  task automatic t_reset;
    logic [31:0] rd;
    logic        e;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({chip_clk_en, symmetrator_en, divider_bypass, sys_clk_out_true,
      sys_clk_out_comp, pready, pslverr, mode_invalid}, 32'h0000_0008);
    check(prdata, 32'h0000_0000);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFFSET, '0, rd, e);
    check(rd, {28'h000_0000, HALF_PERIOD_RESET});
  endtask : t_reset

  task automatic results;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_modes();
    t_ref();
    t_reset();
    results();
  end

  // Whole run needs well under 200 cycles
  initial
  begin
    #(100 * 5000);
    n_errors++;
    results();
  end
endmodule : ccmsd_top_tb_top
`default_nettype wire
